// file: led_port_pkg.sv
// Constants and types shared by the LED display write port
package led_port_pkg;
   // ************************************************************
   // Control word field positions
   // ************************************************************
   localparam int ADDR_LSB   = 0;
   localparam int ADDR_W     = 3;
   localparam int BANK_BIT   = 3;
   localparam int RUN_BIT    = 4;
   localparam int RAW_BIT    = 5;
   localparam int HEX_BIT    = 6;
   localparam int SEQ_BIT    = 7;
   localparam int POINT_BIT  = 7;
   localparam int NIBBLE_W   = 4;
   localparam int DIGITS     = 8;

   // Control word after reset: running, bank A, decoded, code B, no sequence
   localparam logic [7:0] CTRL_RESET = 8'h18;

   // ************************************************************
   // Synchroniser bundle layout
   // ************************************************************
   localparam int PIN_W      = 16;
   localparam int P_FMT_LO   = 0;
   localparam int P_FMT_HI   = 1;
   localparam int P_POINT_N  = 2;
   localparam int P_SEL_LSB  = 3;
   localparam int P_DATA_LSB = 6;
   localparam int P_MODE     = 14;
   localparam int P_WRITE    = 15;

   // ************************************************************
   // Scan timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 5;
   localparam int DIGIT_TIME_NS  = 2000;
   localparam int GAP_TIME_NS    = 100;
   localparam int DIGIT_CYCLES   = DIGIT_TIME_NS / CLK_PERIOD_NS;
   localparam int GAP_CYCLES     = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCAN_CNT_W     = 9;
   localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = SCAN_CNT_W'(DIGIT_CYCLES - 1);
   localparam logic [SCAN_CNT_W-1:0] SCAN_GAP  = SCAN_CNT_W'(GAP_CYCLES);

   // Write sequencing states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SINGLE,
      ST_SEQ
   } wr_state_t;
endpackage

// file: led_driver_write_port.sv
// Write port, display memory and multiplexed scan of an 8-digit LED driver
`timescale 1ns/10ps
`default_nettype none

module led_driver_write_port #(
   parameter bit NO_CTRL_VARIANT = 1'b0
) (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       write_strobe,
   input  wire logic       mode_sel,
   input  wire logic       data_in_0,
   input  wire logic       data_in_1,
   input  wire logic       data_in_2,
   input  wire logic       data_in_3,
   input  wire logic       data_in_4,
   input  wire logic       data_in_5,
   input  wire logic       data_in_6,
   input  wire logic       data_in_7,
   input  wire logic       digit_sel_0,
   input  wire logic       digit_sel_1,
   input  wire logic       digit_sel_2,
   input  wire logic       point_in_n,
   input  wire logic       format_power_sel_high,
   input  wire logic       format_power_sel_low,
   output logic      [7:0] digit_enable,
   output logic      [6:0] segment_out,
   output logic            point_segment_out,
   output logic      [7:0] display_control_word
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [led_port_pkg::PIN_W-1:0]      sync1;
      logic [led_port_pkg::PIN_W-1:0]      sync2;
      logic                                strobe_prev;
      logic [7:0]                          ctrl;
      led_port_pkg::wr_state_t             state;
      logic [led_port_pkg::ADDR_W-1:0]     wr_addr;
      logic [7:0][7:0]                     bank_a;
      logic [7:0][3:0]                     bank_b;
      logic [7:0]                          point;
      logic [7:0]                          raw;
      logic [led_port_pkg::ADDR_W-1:0]     scan_digit;
      logic [led_port_pkg::SCAN_CNT_W-1:0] scan_cnt;
      logic [7:0]                          dig_en;
      logic [6:0]                          seg;
      logic                                seg_point;
   } state_t;

   state_t q_q;
   state_t d_d;

   // Segment order is {g,f,e,d,c,b,a}
   function automatic logic [6:0] font(input logic [3:0] code, input logic hex);
      logic [6:0] s;
      s = 7'h00;
      case (code)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         4'hA: s = hex ? 7'h77 : 7'h40;
         4'hB: s = hex ? 7'h7C : 7'h79;
         4'hC: s = hex ? 7'h39 : 7'h76;
         4'hD: s = hex ? 7'h5E : 7'h38;
         4'hE: s = hex ? 7'h79 : 7'h73;
         4'hF: s = hex ? 7'h71 : 7'h00;
         default: s = 7'h00;
      endcase
      return s;
   endfunction

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // Working copies of the synchronised pins and display decisions
   logic                            edge_w;
   logic                            mode_w;
   logic [7:0]                      data_w;
   logic [led_port_pkg::ADDR_W-1:0] sel_w;
   logic                            run_w;
   logic                            hex_w;
   logic                            bank_a_w;
   logic                            show_w;
   logic [led_port_pkg::ADDR_W-1:0] tgt_w;
   logic                            do_data_w;
   logic [led_port_pkg::ADDR_W-1:0] cd_w;
   logic [6:0]                      seg_w;
   logic                            pt_w;

   always_comb begin
      d_d = q_q;
      // Every pin passes two stages; only stage two is looked at
      d_d.sync1 = {write_strobe, mode_sel,
                   data_in_7, data_in_6, data_in_5, data_in_4,
                   data_in_3, data_in_2, data_in_1, data_in_0,
                   digit_sel_2, digit_sel_1, digit_sel_0,
                   point_in_n, format_power_sel_high, format_power_sel_low};
      d_d.sync2 = q_q.sync1;
      d_d.strobe_prev = q_q.sync2[led_port_pkg::P_WRITE];

      edge_w = q_q.sync2[led_port_pkg::P_WRITE] & ~q_q.strobe_prev;
      mode_w = q_q.sync2[led_port_pkg::P_MODE];
      data_w = q_q.sync2[led_port_pkg::P_DATA_LSB +: 8];
      // Select zero is the address LSB
      sel_w  = q_q.sync2[led_port_pkg::P_SEL_LSB +: led_port_pkg::ADDR_W];

      do_data_w = 1'b0;
      tgt_w     = q_q.wr_addr;
      if (NO_CTRL_VARIANT) begin
         // Three-level format pin; low shuts down
         run_w    = ~q_q.sync2[led_port_pkg::P_FMT_LO];
         hex_w    = q_q.sync2[led_port_pkg::P_FMT_HI];
         bank_a_w = 1'b1;
         // Every edge writes the selected digit
         do_data_w = edge_w;
         tgt_w     = sel_w;
      end else begin
         run_w    = q_q.ctrl[led_port_pkg::RUN_BIT];
         hex_w    = q_q.ctrl[led_port_pkg::HEX_BIT];
         bank_a_w = q_q.ctrl[led_port_pkg::BANK_BIT];
         if (edge_w && mode_w) begin
            // Select high loads the control word
            d_d.ctrl = data_w;
            d_d.wr_addr = data_w[led_port_pkg::ADDR_LSB +: led_port_pkg::ADDR_W];
            // Sequential bit picks the entry mode
            if (data_w[led_port_pkg::SEQ_BIT]) begin
               d_d.state   = led_port_pkg::ST_SEQ;
               d_d.wr_addr = '0;
            end else begin
               d_d.state = led_port_pkg::ST_SINGLE;
            end
         end else if (edge_w && !mode_w) begin
            case (q_q.state)
               led_port_pkg::ST_SINGLE: begin
                  // One write to the latched digit
                  do_data_w = 1'b1;
                  d_d.state = led_port_pkg::ST_IDLE;
               end
               led_port_pkg::ST_SEQ: begin
                  // Digits zero to seven in order, then stop
                  do_data_w   = 1'b1;
                  d_d.wr_addr = q_q.wr_addr + 3'h1;
                  if (q_q.wr_addr == 3'h7) begin
                     d_d.state = led_port_pkg::ST_IDLE;
                  end
               end
               led_port_pkg::ST_IDLE: begin
                  d_d.state = led_port_pkg::ST_IDLE;
               end
               default: begin
                  d_d.state = led_port_pkg::ST_IDLE;
               end
            endcase
         end
      end

      // Display memory write
      if (do_data_w) begin
         if (NO_CTRL_VARIANT) begin
            d_d.bank_a[tgt_w] = {4'h0, data_w[3:0]};
            d_d.point[tgt_w]  = ~q_q.sync2[led_port_pkg::P_POINT_N];
            d_d.raw[tgt_w]    = 1'b0;
         end else if (q_q.ctrl[led_port_pkg::RAW_BIT]) begin
            // Lines zero to seven kept as bits zero to seven; line seven is the point
            d_d.bank_a[tgt_w] = data_w;
            d_d.raw[tgt_w]    = 1'b1;
         end else begin
            if (bank_a_w) begin
               d_d.bank_a[tgt_w] = {4'h0, data_w[3:0]};
            end else begin
               d_d.bank_b[tgt_w] = data_w[3:0];
            end
            d_d.point[tgt_w] = data_w[led_port_pkg::POINT_BIT];
            d_d.raw[tgt_w]   = 1'b0;
         end
      end

      // Shutdown and update in progress blank the display
      show_w = run_w & (NO_CTRL_VARIANT | (q_q.state != led_port_pkg::ST_SEQ));

      // Scan timer; frozen in shutdown as the oscillator stops
      if (run_w) begin
         if (q_q.scan_cnt == led_port_pkg::SCAN_LAST) begin
            d_d.scan_cnt   = '0;
            d_d.scan_digit = q_q.scan_digit + 3'h1;
         end else begin
            d_d.scan_cnt = q_q.scan_cnt + 9'h001;
         end
      end

      // Font chosen per control word, or per format pin in the control-free build; raw digits bypass it
      cd_w = q_q.scan_digit;
      if (q_q.raw[cd_w]) begin
         seg_w = q_q.bank_a[cd_w][6:0];
         pt_w  = q_q.bank_a[cd_w][7];
      end else begin
         seg_w = font(bank_a_w ? q_q.bank_a[cd_w][3:0] : q_q.bank_b[cd_w], hex_w);
         pt_w  = q_q.point[cd_w];
      end

      // Gap at each digit start keeps enables from overlapping
      if (show_w && (q_q.scan_cnt >= led_port_pkg::SCAN_GAP)) begin
         d_d.dig_en    = 8'h01 << cd_w;
         d_d.seg       = seg_w;
         d_d.seg_point = pt_w;
      end else begin
         d_d.dig_en    = 8'h00;
         d_d.seg       = 7'h00;
         d_d.seg_point = 1'b0;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Constant reset: memory cleared, display running in code B
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         q_q       <= '0;
         q_q.ctrl  <= led_port_pkg::CTRL_RESET;
         q_q.state <= led_port_pkg::ST_IDLE;
      end else begin
         q_q <= d_d;
      end
   end

   // Outputs straight from the state flops
   assign digit_enable         = q_q.dig_en;
   assign segment_out          = q_q.seg;
   assign point_segment_out    = q_q.seg_point;
   assign display_control_word = q_q.ctrl;

endmodule // led_driver_write_port

`default_nettype wire

// file: led_driver_write_port_properties.sv
// Pin-level assertions for the LED display write port
`timescale 1ns/10ps
`default_nettype none
module led_port_checker (
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       write_strobe,
   input wire logic       mode_sel,
   input wire logic       data_in_0,
   input wire logic       data_in_1,
   input wire logic       data_in_2,
   input wire logic       data_in_3,
   input wire logic       data_in_4,
   input wire logic       data_in_5,
   input wire logic       data_in_6,
   input wire logic       data_in_7,
   input wire logic       format_power_sel_low,
   input wire logic [7:0] digit_enable,
   input wire logic [7:0] display_control_word
);
   // ****
   // Properties
   // ****
   wire logic [7:0] din = {data_in_7, data_in_6, data_in_5, data_in_4,
                           data_in_3, data_in_2, data_in_1, data_in_0};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_ctrl_capture: assert property (
      $rose(write_strobe) && mode_sel |-> ##[2:6] display_control_word == din)
      else $error("control word not loaded from data lines");
   a_ctrl_cause: assert property (
      !$stable(display_control_word) |-> write_strobe && mode_sel)
      else $error("control word moved without a control write");
   a_data_no_ctrl: assert property (
      $rose(write_strobe) && !mode_sel |-> ##1 $stable(display_control_word) [*8])
      else $error("data write touched the control word");
   a_shutdown_blank: assert property (
      (display_control_word[4] == 1'b0) [*3] |-> digit_enable == 8'h00)
      else $error("digit driven during shutdown");
   a_seq_blank: assert property (
      $rose(write_strobe) && mode_sel && data_in_7 |-> ##6 (digit_enable == 8'h00) [*8])
      else $error("display not blanked for sequential update");
   a_enable_onehot: assert property ($onehot0(digit_enable))
      else $error("more than one digit enabled");
   a_enable_gap: assert property (
      digit_enable != 8'h00 && !$stable(digit_enable) |-> $past(digit_enable) == 8'h00)
      else $error("digit enables overlap without a gap");
   a_gap_len: assert property (
      $fell(|digit_enable) |-> (digit_enable == 8'h00) [*8])
      else $error("gap between digits too short");
   a_format_blank: assert property (
      format_power_sel_low [*4] |-> digit_enable == 8'h00)
      else $error("digit driven while the format pin is low");
   // Main scenarios reached
   c_seq_start: cover property ($rose(write_strobe) && mode_sel && data_in_7);
   c_shutdown: cover property (display_control_word[4] == 1'b0);
   c_data_write: cover property ($rose(write_strobe) && !mode_sel);
endmodule // led_port_checker

bind led_driver_write_port led_port_checker led_port_checker_inst (
   .core_clk, .arst_n, .write_strobe, .mode_sel, .data_in_0, .data_in_1,
   .data_in_2, .data_in_3, .data_in_4, .data_in_5, .data_in_6, .data_in_7,
   .format_power_sel_low, .digit_enable, .display_control_word
);
`default_nettype wire

// file: host_bus_model.sv
// Host bus model driving strobe, select, data and digit-select pins
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
   input  wire logic       core_clk,
   output logic            write_strobe,
   output logic            mode_sel,
   output logic      [7:0] data,
   output logic      [2:0] digit_sel
);
   // Parked bus at time zero
   initial begin
      write_strobe = 1'b0;
      mode_sel = 1'b0;
      data = 8'h00;
      digit_sel = 3'h0;
   end

   // One write; long setup and hold since pins pass a two-stage sync
   task automatic put(input logic m, input logic [7:0] d);
      @(negedge core_clk);
      mode_sel = m;
      data = d;
      digit_sel = d[2:0];
      repeat (4) @(negedge core_clk);
      write_strobe = 1'b1;
      repeat (8) @(negedge core_clk);
      write_strobe = 1'b0;
      // Hold over: lines no longer carry the written value
      data = ~d;
      mode_sel = ~m;
      repeat (3) @(negedge core_clk);
   endtask
endmodule // host_bus_model
`default_nettype wire

// file: led_driver_write_port_tb.sv
// Self-checking bench for the LED display write port
`timescale 1ns/10ps
`default_nettype none
module led_driver_write_port_tb;
   logic            core_clk = 1'b0;
   logic            arst_n = 1'b0;
   int              errors = 0;
   int              check_count = 0;
   wire logic       write_strobe;
   wire logic       mode_sel;
   wire logic [7:0] data;
   wire logic [2:0] digit_sel;
   wire logic [7:0] digit_enable;
   wire logic [6:0] segment_out;
   wire logic       point_segment_out;
   wire logic [7:0] display_control_word;
   // Control-free build: format pin halves and its outputs
   logic            fmt_high = 1'b0;
   logic            fmt_low = 1'b0;
   logic            use_var = 1'b0;
   wire logic [7:0] var_enable;
   wire logic [6:0] var_segment;
   wire logic       var_point;
   wire logic [7:0] var_ctrl;
   // Display under test, picked per scenario
   wire logic [7:0] watch_en  = use_var ? var_enable : digit_enable;
   wire logic [6:0] watch_seg = use_var ? var_segment : segment_out;
   wire logic       watch_pt  = use_var ? var_point : point_segment_out;

   always #2.5 core_clk = ~core_clk;

   host_bus_model host_bus_model_inst (.core_clk(core_clk), .write_strobe(write_strobe),
      .mode_sel(mode_sel), .data(data), .digit_sel(digit_sel));

   // Variant pins parked: this instance is the control word build
   led_driver_write_port led_driver_write_port_inst (.core_clk(core_clk), .arst_n(arst_n),
      .write_strobe(write_strobe), .mode_sel(mode_sel), .data_in_0(data[0]),
      .data_in_1(data[1]), .data_in_2(data[2]), .data_in_3(data[3]), .data_in_4(data[4]),
      .data_in_5(data[5]), .data_in_6(data[6]), .data_in_7(data[7]),
      .digit_sel_0(digit_sel[0]), .digit_sel_1(digit_sel[1]), .digit_sel_2(digit_sel[2]),
      .point_in_n(1'b1), .format_power_sel_high(1'b0), .format_power_sel_low(1'b0),
      .digit_enable(digit_enable), .segment_out(segment_out),
      .point_segment_out(point_segment_out), .display_control_word(display_control_word));

   // Control-free build on the same bus; no select pin, point rides on line seven
   led_driver_write_port #(.NO_CTRL_VARIANT(1'b1)) led_driver_write_port_var_inst (
      .core_clk(core_clk), .arst_n(arst_n),
      .write_strobe(write_strobe), .mode_sel(1'b0), .data_in_0(data[0]),
      .data_in_1(data[1]), .data_in_2(data[2]), .data_in_3(data[3]), .data_in_4(data[4]),
      .data_in_5(data[5]), .data_in_6(data[6]), .data_in_7(data[7]),
      .digit_sel_0(digit_sel[0]), .digit_sel_1(digit_sel[1]), .digit_sel_2(digit_sel[2]),
      .point_in_n(data[7]), .format_power_sel_high(fmt_high),
      .format_power_sel_low(fmt_low),
      .digit_enable(var_enable), .segment_out(var_segment),
      .point_segment_out(var_point), .display_control_word(var_ctrl));

   // ****
   // Tasks
   // ****
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic m, input logic [7:0] d);
      host_bus_model_inst.put(m, d);
   endtask

   // Wait for a digit slot, bounded by 4000 cycles, just over one full scan
   task automatic show(input int d, input logic [6:0] seg, input logic pt);
      int n;
      n = 0;
      while (watch_en !== (8'h01 << d) && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      check("digit enable", watch_en, 8'h01 << d);
      check("segments", {1'b0, watch_seg}, {1'b0, seg});
      check("point", {7'h00, watch_pt}, {7'h00, pt});
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog: tests need about 50k cycles at worst
   initial begin
      #350000;
      errors++;
      end_of_test();
   end

   // ****
   // Tests
   // ****
   initial begin
      repeat (10) @(negedge core_clk);
      arst_n = 1'b1;
      @(negedge core_clk);
      check("control word", display_control_word, 8'h18);
      wr(1'b1, 8'h5B);
      check("control word", display_control_word, 8'h5B);
      wr(1'b0, 8'h88);
      show(3, 7'h7F, 1'b1);
      wr(1'b0, 8'h00);
      show(3, 7'h7F, 1'b1);
      wr(1'b1, 8'h31);
      wr(1'b0, 8'hA5);
      show(1, 7'h25, 1'b1);
      wr(1'b1, 8'h48);
      repeat (900) begin
         @(negedge core_clk);
         check("blank enable", digit_enable, 8'h00);
      end
      // Sequence: digit 0 differs so order errors show
      wr(1'b1, 8'hD8);
      wr(1'b0, 8'h01);
      repeat (7) wr(1'b0, 8'h08);
      wr(1'b0, 8'h00);
      show(0, 7'h06, 1'b0);
      show(1, 7'h7F, 1'b0);
      wr(1'b1, 8'h50);
      wr(1'b0, 8'h08);
      show(0, 7'h7F, 1'b0);
      wr(1'b1, 8'h58);
      show(0, 7'h06, 1'b0);
      wr(1'b1, 8'h5A);
      wr(1'b0, 8'h0F);
      show(2, 7'h71, 1'b0);
      wr(1'b1, 8'h18);
      show(2, 7'h00, 1'b0);
      // Control-free build: low data bits double as the digit address
      use_var = 1'b1;
      fmt_high = 1'b1;
      wr(1'b0, 8'h0B);
      show(3, 7'h7C, 1'b1);
      // Font pin passes two sync stages before the display sees it
      fmt_high = 1'b0;
      repeat (5) @(negedge core_clk);
      show(3, 7'h79, 1'b1);
      wr(1'b0, 8'h85);
      show(5, 7'h6D, 1'b0);
      fmt_low = 1'b1;
      repeat (5) @(negedge core_clk);
      repeat (450) begin
         @(negedge core_clk);
         check("variant blank", var_enable, 8'h00);
      end
      check("variant control word", var_ctrl, 8'h18);
      end_of_test();
   end
endmodule // led_driver_write_port_tb
`default_nettype wire
